// *** verilog/hcc_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the channel.
`ifndef HCC_CONSTS_SVH
`define HCC_CONSTS_SVH
`define HCC_OFF_MODE 8'h00
`define HCC_OFF_CMD 8'h04
`define HCC_OFF_STATUS 8'h08
`define HCC_OFF_MASK 8'h0C
`define HCC_OFF_ADDR1 8'h10
`define HCC_OFF_ADDR2 8'h14
`define HCC_OFF_ADDR3 8'h18
`define HCC_OFF_ADDR4 8'h1C
`define HCC_OFF_MAX_FRAME_LENGTH 8'h20
`define HCC_OFF_UNMATCH 8'h24
`define HCC_OFF_TXCTL 8'h28
`define HCC_OFF_TXDATA 8'h2C
`define HCC_OFF_TXSTAT 8'h30
`define HCC_OFF_RXSTAT 8'h34
`define HCC_PROTO_HDLC 2'b00
`define HCC_MODE_TXEN 4
`define HCC_MODE_RXEN 5
`define HCC_MODE_FLG 7
`define HCC_MODE_RXBIE 8
`define HCC_MODE_LSIE 9
`define HCC_CMD_STOP 2'd1
`define HCC_CMD_RESTART 2'd2
`define HCC_CMD_HUNT 2'd3
`define HCC_FLAG_BYTE 8'h7E
`define HCC_ABORT_BYTE 8'hFE
`define HCC_IDLE_BYTE 8'hFF
`define HCC_POLL_FLAGS 5'd8
`define HCC_POLL_IDLE 5'd16
`define HCC_ABORT_ONES 4'd7
`define HCC_IDLE_ONES 4'd15
`define HCC_RST_MODE 16'h0000
`define HCC_RST_MASK 16'hFFFF
`define HCC_RST_ADDR 16'h0000
`define HCC_RST_MAX_FRAME_LENGTH 16'hFFFF
`endif

// *** verilog/hcc_pkg.sv ***
// Types shared by the channel files.
package hcc_pkg;
  typedef enum logic [2:0] {TX_OFF, TX_IDLE, TX_FRAME, TX_ABORT, TX_HALT} hcc_tx_e;
  typedef enum logic [0:0] {RX_HUNT, RX_FRAME} hcc_rx_e;
  // Receive closing status bits.
  typedef struct packed {
    logic hunt;
    logic crc;
    logic overrun;
    logic cd_lost;
    logic aborted;
    logic nonoctet;
    logic frame_too_long_flag;
  } hcc_rxflags_s;
endpackage : hcc_pkg

// *** verilog/hcc_pin_sync.sv ***
// Two-flop synchroniser with edge pulses for the serial line pins.
`timescale 1ns/1ps
`default_nettype none
module hcc_pin_sync #(
  parameter int W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } hcc_sync_s;
  hcc_sync_s s;
  hcc_sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.s2;
  assign rise = s.s2 & ~s.s3;
  assign fall = ~s.s2 & s.s3;
endmodule : hcc_pin_sync
`default_nettype wire

// *** verilog/hcc_channel.sv ***
// HDLC serial channel: commands, transmit halt and abort, receive address match and length check.
//
// Behaviour
// - HDLC operation only when protocol_select is 00.
// - Receive errors reported in receive status.
// - Underrun and CTS loss reported in transmit status.
// - Line states shown; change raises maskable interrupt.
// - After reset and enable, transmitter polls descriptor.
// - Stop mid-frame drains FIFO, then aborts.
// - Stop keeps pointer, fetches and starts nothing.
// - Abort is 01111111, then flags or ones.
// - Restart resumes at current descriptor pointer.
// - Halted until restart after stop or error.
// - After reset receiver uses first descriptor.
// - Hunt aborts frame, closes buffer, signals, rescans.
// - Masked compare against four 16-bit addresses.
// - Matching frame stored from address byte on.
// - Unmatched error-free frame counted, not stored.
// - Too-long frame truncated, flagged with length.
// - Length counts all bytes between flags.
// - Downcounter loaded from maximum, decremented per byte.
// - Poll every 16 clocks, or 8 with flags.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_consts.svh"
module hcc_channel #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic rx_data,
  input wire logic cd_n,
  input wire logic cts_n,
  output logic tx_data,
  output logic [7:0] rx_store_data,
  output logic rx_store_valid,
  input wire logic rx_store_ready,
  input wire logic rx_crc_error,
  output logic irq
);
  import hcc_pkg::*;

  typedef struct packed {
    logic [15:0] serial_channel_mode_reg;
    logic [15:0] rx_address_mask;
    logic [15:0] rx_match_address_one;
    logic [15:0] rx_match_address_two;
    logic [15:0] rx_match_address_three;
    logic [15:0] rx_match_address_four;
    logic [15:0] max_frame_length;
    logic [15:0] unmatched_address_counter;
    logic tx_ready;
    logic tx_last;
    logic [7:0] tx_descriptor_pointer;
    logic [FIFO_DEPTH-1:0][7:0] tx_fifo;
    logic [$clog2(FIFO_DEPTH)-1:0] tx_wp;
    logic [$clog2(FIFO_DEPTH)-1:0] tx_rp;
    logic [$clog2(FIFO_DEPTH):0] tx_cnt;
    hcc_tx_e tx_st;
    logic [7:0] tx_sr;
    logic [2:0] tx_bits;
    logic [4:0] tx_poll;
    logic tx_start;
    logic tx_stop;
    logic tx_underrun;
    logic tx_cts_lost;
    logic tx_data;
    hcc_rx_e rx_st;
    logic [7:0] rx_sr;
    logic [3:0] rx_ones;
    logic [2:0] rx_bits;
    logic [15:0] rx_bytes;
    logic [15:0] rx_down;
    logic [7:0] rx_addr_lo;
    logic [7:0] rx_addr_hi;
    logic rx_matched;
    logic rx_long;
    logic rx_hi_pend;
    logic [15:0] rx_len;
    hcc_rxflags_s rx_flags;
    logic rx_buffer_event;
    logic [7:0] rx_desc;
    logic store_valid;
    logic [7:0] store_data;
    logic [2:0] line_prev;
    logic line_chg;
    logic [31:0] prdata;
  } hcc_state_s;

  hcc_state_s s;
  hcc_state_s next_s;
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;
  logic wr;
  logic push;
  logic pop;
  logic mapped;
  logic [31:0] rd_val;
  logic [7:0] b;
  logic emit;
  logic [7:0] emit_byte;
  logic close;
  hcc_rxflags_s cflags;
  logic [15:0] full_addr;
  logic [2:0] line_now;

  hcc_pin_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({cts_n, cd_n, rx_data, rx_clk, tx_clk}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Idle, carrier detect and clear-to-send, the last two shown as asserted-high.
  assign line_now = {~lvl[4], ~lvl[3], s.rx_ones >= `HCC_IDLE_ONES};

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] r,
                                    input logic [15:0] m);
    addr_hit = ((a ^ r) & m) == 16'h0000;
  endfunction : addr_hit

  always_comb begin
    case (paddr)
      `HCC_OFF_MODE: rd_val = {16'h0000, s.serial_channel_mode_reg};
      `HCC_OFF_STATUS: rd_val = {25'h000_0000, line_now, 2'b00, s.rx_buffer_event, s.line_chg};
      `HCC_OFF_MASK: rd_val = {16'h0000, s.rx_address_mask};
      `HCC_OFF_ADDR1: rd_val = {16'h0000, s.rx_match_address_one};
      `HCC_OFF_ADDR2: rd_val = {16'h0000, s.rx_match_address_two};
      `HCC_OFF_ADDR3: rd_val = {16'h0000, s.rx_match_address_three};
      `HCC_OFF_ADDR4: rd_val = {16'h0000, s.rx_match_address_four};
      `HCC_OFF_MAX_FRAME_LENGTH: rd_val = {16'h0000, s.max_frame_length};
      `HCC_OFF_UNMATCH: rd_val = {16'h0000, s.unmatched_address_counter};
      `HCC_OFF_TXCTL: rd_val = {30'h0000_0000, s.tx_last, s.tx_ready};
      `HCC_OFF_TXSTAT: rd_val = {13'h0000, 3'(s.tx_cnt), s.tx_descriptor_pointer, 5'h00,
                                 s.tx_st == TX_HALT, s.tx_cts_lost, s.tx_underrun};
      `HCC_OFF_RXSTAT: rd_val = {s.rx_desc, 1'b0, s.rx_flags, s.rx_len};
      default: rd_val = 32'h0000_0000;
    endcase
    mapped = (paddr[1:0] == 2'b00) && (paddr <= `HCC_OFF_RXSTAT);
  end

  always_comb begin
    next_s = s;
    next_s.store_valid = 1'b0;
    wr = psel & penable & pwrite & mapped;
    push = 1'b0;
    pop = 1'b0;
    b = `HCC_IDLE_BYTE;
    emit = 1'b0;
    emit_byte = s.rx_addr_hi;
    close = 1'b0;
    cflags = '0;
    full_addr = 16'h0000;

    // Bus side. Read data is captured in the setup cycle so the access phase needs no wait.
    if (psel && !penable) begin
      next_s.prdata = rd_val;
    end
    if (wr) begin
      case (paddr)
        `HCC_OFF_MODE: next_s.serial_channel_mode_reg = pwdata[15:0];
        `HCC_OFF_STATUS: begin
          if (pwdata[0]) begin
            next_s.line_chg = 1'b0;
          end
          if (pwdata[1]) begin
            next_s.rx_buffer_event = 1'b0;
          end
        end
        `HCC_OFF_MASK: next_s.rx_address_mask = pwdata[15:0];
        `HCC_OFF_ADDR1: next_s.rx_match_address_one = pwdata[15:0];
        `HCC_OFF_ADDR2: next_s.rx_match_address_two = pwdata[15:0];
        `HCC_OFF_ADDR3: next_s.rx_match_address_three = pwdata[15:0];
        `HCC_OFF_ADDR4: next_s.rx_match_address_four = pwdata[15:0];
        `HCC_OFF_MAX_FRAME_LENGTH: next_s.max_frame_length = pwdata[15:0];
        `HCC_OFF_UNMATCH: next_s.unmatched_address_counter = pwdata[15:0];
        `HCC_OFF_TXCTL: begin
          next_s.tx_ready = pwdata[0];
          next_s.tx_last = pwdata[1];
        end
        `HCC_OFF_TXDATA: push = (s.tx_cnt != FIFO_DEPTH);
        `HCC_OFF_CMD: begin
          case (pwdata[1:0])
            `HCC_CMD_STOP: begin
              if (s.tx_st == TX_FRAME) begin
                next_s.tx_stop = 1'b1;
              end else begin
                next_s.tx_st = TX_HALT;
              end
            end
            `HCC_CMD_RESTART: begin
              if (s.tx_st == TX_HALT) begin
                next_s.tx_st = TX_IDLE;
                next_s.tx_underrun = 1'b0;
                next_s.tx_cts_lost = 1'b0;
                next_s.tx_poll = 5'd0;
              end
            end
            `HCC_CMD_HUNT: begin
              if (s.rx_st == RX_FRAME) begin
                close = 1'b1;
                cflags.hunt = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    if (push) begin
      next_s.tx_fifo[s.tx_wp] = pwdata[7:0];
      next_s.tx_wp = s.tx_wp + 1'b1;
    end

    // Transmitter. A halted channel stays halted across a disable so restart is still needed.
    if (s.serial_channel_mode_reg[1:0] != `HCC_PROTO_HDLC ||
        !s.serial_channel_mode_reg[`HCC_MODE_TXEN]) begin
      if (s.tx_st != TX_HALT) begin
        next_s.tx_st = TX_OFF;
      end
      next_s.tx_bits = 3'd0;
      next_s.tx_stop = 1'b0;
      next_s.tx_data = 1'b1;
    end else if (s.tx_st == TX_OFF) begin
      next_s.tx_st = TX_IDLE;
      next_s.tx_poll = 5'd0;
    end else if (fall[0]) begin
      if (s.tx_st == TX_IDLE) begin
        next_s.tx_poll = s.tx_poll + 5'd1;
        if (s.tx_poll == (s.serial_channel_mode_reg[`HCC_MODE_FLG] ?
            `HCC_POLL_FLAGS : `HCC_POLL_IDLE) - 5'd1) begin
          next_s.tx_poll = 5'd0;
          next_s.tx_start = s.tx_ready;
        end
      end
      if (s.tx_bits == 3'd0) begin
        b = s.serial_channel_mode_reg[`HCC_MODE_FLG] ? `HCC_FLAG_BYTE : `HCC_IDLE_BYTE;
        case (s.tx_st)
          TX_IDLE: begin
            if (s.tx_start) begin
              b = `HCC_FLAG_BYTE;
              next_s.tx_start = 1'b0;
              next_s.tx_st = TX_FRAME;
            end
          end
          TX_FRAME: begin
            // Loss of clear-to-send halts; automatic retransmission is not offered.
            if (lvl[4]) begin
              next_s.tx_cts_lost = 1'b1;
              b = `HCC_ABORT_BYTE;
              next_s.tx_st = TX_ABORT;
            end else if (s.tx_cnt != 0) begin
              b = s.tx_fifo[s.tx_rp];
              pop = 1'b1;
            end else if (s.tx_stop) begin
              b = `HCC_ABORT_BYTE;
              next_s.tx_st = TX_ABORT;
            end else if (s.tx_last) begin
              b = `HCC_FLAG_BYTE;
              next_s.tx_ready = 1'b0;
              next_s.tx_descriptor_pointer = s.tx_descriptor_pointer + 8'd1;
              next_s.tx_st = TX_IDLE;
            end else begin
              next_s.tx_underrun = 1'b1;
              b = `HCC_ABORT_BYTE;
              next_s.tx_st = TX_ABORT;
            end
          end
          TX_ABORT: begin
            next_s.tx_stop = 1'b0;
            next_s.tx_st = TX_HALT;
          end
          default: begin
          end
        endcase
        next_s.tx_data = b[0];
        next_s.tx_sr = {1'b0, b[7:1]};
      end else begin
        next_s.tx_data = s.tx_sr[0];
        next_s.tx_sr = {1'b0, s.tx_sr[7:1]};
      end
      next_s.tx_bits = s.tx_bits + 3'd1;
    end
    if (pop) begin
      next_s.tx_rp = s.tx_rp + 1'b1;
    end
    next_s.tx_cnt = s.tx_cnt + {{$clog2(FIFO_DEPTH){1'b0}}, push} -
                    {{$clog2(FIFO_DEPTH){1'b0}}, pop};

    // Receiver; the high address byte is written one cycle after the low one.
    if (s.rx_hi_pend) begin
      next_s.rx_hi_pend = 1'b0;
      emit = 1'b1;
    end
    if (s.serial_channel_mode_reg[1:0] != `HCC_PROTO_HDLC ||
        !s.serial_channel_mode_reg[`HCC_MODE_RXEN]) begin
      next_s.rx_st = RX_HUNT;
      next_s.rx_hi_pend = 1'b0;
      emit = 1'b0;
    end else if (rise[1]) begin
      next_s.rx_sr = {lvl[2], s.rx_sr[7:1]};
      next_s.rx_ones = lvl[2] ? (s.rx_ones == 4'hF ? 4'hF : s.rx_ones + 4'd1) : 4'd0;
      if (s.rx_st == RX_HUNT) begin
        if (next_s.rx_sr == `HCC_FLAG_BYTE) begin
          next_s.rx_st = RX_FRAME;
          next_s.rx_bits = 3'd0;
          next_s.rx_bytes = 16'h0000;
        end
      end else if (!close) begin
        if (lvl[3]) begin
          close = 1'b1;
          cflags.cd_lost = 1'b1;
        end else if (next_s.rx_ones >= `HCC_ABORT_ONES) begin
          close = 1'b1;
          cflags.aborted = 1'b1;
        end else if (next_s.rx_sr == `HCC_FLAG_BYTE) begin
          if (s.rx_bytes != 16'h0000) begin
            close = 1'b1;
            cflags.nonoctet = (s.rx_bits != 3'd7);
            cflags.crc = rx_crc_error;
          end
          next_s.rx_bits = 3'd0;
        end else begin
          next_s.rx_bits = s.rx_bits + 3'd1;
          if (s.rx_bits == 3'd7) begin
            next_s.rx_bytes = s.rx_bytes + 16'd1;
            if (s.rx_bytes == 16'h0000) begin
              next_s.rx_down = s.max_frame_length;
            end
            if (s.rx_long || next_s.rx_down == 16'h0000) begin
              next_s.rx_long = 1'b1;
            end else begin
              next_s.rx_down = next_s.rx_down - 16'd1;
              if (s.rx_bytes == 16'h0000) begin
                next_s.rx_addr_lo = next_s.rx_sr;
              end else if (s.rx_bytes == 16'h0001) begin
                full_addr = {next_s.rx_sr, s.rx_addr_lo};
                next_s.rx_addr_hi = next_s.rx_sr;
                next_s.rx_matched = addr_hit(full_addr, s.rx_match_address_one, s.rx_address_mask) |
                  addr_hit(full_addr, s.rx_match_address_two, s.rx_address_mask) |
                  addr_hit(full_addr, s.rx_match_address_three, s.rx_address_mask) |
                  addr_hit(full_addr, s.rx_match_address_four, s.rx_address_mask);
                if (next_s.rx_matched) begin
                  emit = 1'b1;
                  emit_byte = s.rx_addr_lo;
                  next_s.rx_hi_pend = 1'b1;
                end
              end else if (s.rx_matched) begin
                emit = 1'b1;
                emit_byte = next_s.rx_sr;
              end
            end
          end
        end
      end
    end
    // A byte that the buffer cannot take overruns the frame.
    if (emit && !close) begin
      if (rx_store_ready) begin
        next_s.store_valid = 1'b1;
        next_s.store_data = emit_byte;
      end else begin
        close = 1'b1;
        cflags.overrun = 1'b1;
      end
    end
    if (close) begin
      cflags.frame_too_long_flag = s.rx_long | next_s.rx_long;
      if (cflags == '0 && !s.rx_matched) begin
        next_s.unmatched_address_counter = s.unmatched_address_counter + 16'd1;
      end else begin
        next_s.rx_len = next_s.rx_bytes;
        next_s.rx_flags = cflags;
        next_s.rx_desc = s.rx_desc + 8'd1;
        next_s.rx_buffer_event = 1'b1;
      end
      // A close on a flag, even with a CRC or non-octet error, shares its flag with the next frame; hunt, carrier loss, abort and overrun resume the flag scan.
      next_s.rx_st = (cflags[6:1] == 6'h00 && !cflags.crc) ? RX_FRAME : RX_HUNT;
      if (cflags.nonoctet || cflags.crc || cflags[6:1] != 6'h00) begin
        next_s.rx_st = (cflags.hunt || cflags.cd_lost || cflags.aborted || cflags.overrun) ?
                       RX_HUNT : RX_FRAME;
      end
      next_s.rx_bits = 3'd0;
      next_s.rx_bytes = 16'h0000;
      next_s.rx_long = 1'b0;
      next_s.rx_matched = 1'b0;
      next_s.rx_hi_pend = 1'b0;
    end

    // Line change detection; a change in the clearing cycle still sets the bit.
    next_s.line_prev = line_now;
    if (line_now != s.line_prev) begin
      next_s.line_chg = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.serial_channel_mode_reg <= `HCC_RST_MODE;
      s.rx_address_mask <= `HCC_RST_MASK;
      s.rx_match_address_one <= `HCC_RST_ADDR;
      s.rx_match_address_two <= `HCC_RST_ADDR;
      s.rx_match_address_three <= `HCC_RST_ADDR;
      s.rx_match_address_four <= `HCC_RST_ADDR;
      s.max_frame_length <= `HCC_RST_MAX_FRAME_LENGTH;
      s.tx_st <= TX_OFF;
      s.rx_st <= RX_HUNT;
      s.tx_data <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (!mapped | (pwrite & (paddr == `HCC_OFF_TXDATA) &
                   (s.tx_cnt == FIFO_DEPTH)));
  assign tx_data = s.tx_data;
  assign rx_store_data = s.store_data;
  assign rx_store_valid = s.store_valid;
  assign irq = (s.line_chg & s.serial_channel_mode_reg[`HCC_MODE_LSIE]) |
               (s.rx_buffer_event & s.serial_channel_mode_reg[`HCC_MODE_RXBIE]);
endmodule : hcc_channel
`default_nettype wire

// *** sim/hcc_monitor.sv ***
// Port checker for the serial channel, attached to its top module.
`timescale 1ns/1ps
`default_nettype none
module hcc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_data,
  input wire logic rx_store_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  logic half;
  assign acc = psel && penable;
  assign bad = (paddr[1:0] != 2'b00) || (paddr > 8'h34);
  assign half = !bad && (paddr >= 8'h0C) && (paddr <= 8'h20);
  sequence s_pair;
    rx_store_valid ##1 rx_store_valid;
  endsequence
  sequence s_quiet;
    !rx_store_valid [*8];
  endsequence
  a_ready_high: assert property (acc |-> pready) else $error("pready low in access");
  a_err_unmapped: assert property (acc && bad |-> pslverr) else $error("no error on bad address");
  a_err_idle: assert property (!acc |-> !pslverr) else $error("error outside access");
  a_err_mapped: assert property (acc && !bad && paddr != 8'h2C |-> !pslverr)
    else $error("error on mapped address");
  a_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_upper_zero: assert property (acc && !pwrite && half |-> prdata[31:16] == 16'h0000)
    else $error("upper half of short register not zero");
  a_store_pair: assert property (s_pair |=> s_quiet)
    else $error("more than two stores back to back");
  a_tx_bit_hold: assert property ($changed(tx_data) |=> $stable(tx_data) [*6])
    else $error("transmit bit shorter than a link clock");
endmodule : hcc_monitor
bind hcc_channel hcc_monitor u_hcc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_data(tx_data), .rx_store_valid(rx_store_valid));
`default_nettype wire

// *** sim/hcc_peer.sv ***
// Remote station model: clocks the link and drives and watches the serial lines.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_consts.svh"
module hcc_peer (
  output logic tx_clk,
  output logic rx_clk,
  output logic rx_data,
  input wire logic tx_data,
  output logic [7:0] aborts
);
  logic [7:0] win;
  // The transmit clock runs free because the channel polls on it between frames.
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    rx_data = 1'b1;
    aborts = 8'h00;
    win = 8'hFF;
    #5;
    forever #32 tx_clk = ~tx_clk;
  end
  // Bits are launched on the falling edge, so the rising edge sees them settled.
  always @(posedge tx_clk) begin
    win = {tx_data, win[7:1]};
    if (win == `HCC_ABORT_BYTE) aborts = aborts + 8'h01;
  end
  // The receive clock only runs while a byte is sent; after it the line shows the inverse.
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rx_data = b[i];
      #32 rx_clk = 1'b1;
      #32 rx_clk = 1'b0;
    end
    rx_data = ~b[7];
  endtask : send
endmodule : hcc_peer
`default_nettype wire

// *** sim/hcc_channel_test.sv ***
// Self-checking bench for the serial channel with a remote station model.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_consts.svh"
module hcc_channel_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic tx_clk, rx_clk, rx_data, cd_n, cts_n, tx_data, irq;
  logic rx_store_valid, rx_store_ready, rx_crc_error;
  logic [7:0] paddr, rx_store_data, aborts;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] ra;
  logic [7:0] exp_q[$];
  logic [7:0] ra_t [6] = '{8'h00, 8'h0C, 8'h10, 8'h1C, 8'h20, 8'h24};
  logic [31:0] rv_t [6] = '{0, 32'h0000_FFFF, 0, 0, 32'h0000_FFFF, 0};
  logic [7:0] txb [4] = '{8'h3C, 8'h5A, 8'h66, 8'h18};
  int n_errors = 0;
  int check_count = 0;
  hcc_channel u_hcc_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data(rx_data), .cd_n(cd_n),
    .cts_n(cts_n), .tx_data(tx_data), .rx_store_data(rx_store_data),
    .rx_store_valid(rx_store_valid), .rx_store_ready(rx_store_ready),
    .rx_crc_error(rx_crc_error), .irq(irq));
  hcc_peer u_hcc_peer (.tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data(rx_data),
    .tx_data(tx_data), .aborts(aborts));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Polls until the field shows the value, so slow link events need no fixed delay.
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 32'h0000_0000);
      n++;
    end while ((rdat & m) !== e && n < 500);
    chk(rdat & m, e);
  endtask : rc
  task automatic frame(input logic [7:0] q[$], input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(q[i]);
    u_hcc_peer.send(`HCC_FLAG_BYTE);
    foreach (q[i]) u_hcc_peer.send(q[i]);
    u_hcc_peer.send(`HCC_FLAG_BYTE);
  endtask : frame
  // A store with nothing expected is compared against a value no byte can hold.
  always @(negedge pclk) begin
    if (rx_store_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'(rx_store_data), 32'h0000_0100);
      else chk(32'(rx_store_data), 32'(exp_q.pop_front()));
    end
  end
  initial begin
    #300000;
    n_errors++;
    summarize();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cd_n = 1'b0;
    cts_n = 1'b0;
    rx_store_ready = 1'b1;
    rx_crc_error = 1'b0;
    void'($urandom(15864));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rc(ra_t[i], 32'hFFFF_FFFF, rv_t[i]);
    xfer(1'b0, 8'h38, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    ra = 16'($urandom);
    xfer(1'b1, `HCC_OFF_MASK, {16'h5A5A, ra});
    rc(`HCC_OFF_MASK, 32'hFFFF_FFFF, {16'h0000, ra});
    rc(`HCC_OFF_STATUS, 32'h0000_0060, 32'h0000_0060);
    $display("registers done");
    ra = ra & 16'h3C3C;
    xfer(1'b1, `HCC_OFF_MASK, 32'h0000_FFFF);
    xfer(1'b1, `HCC_OFF_ADDR3, {16'h0000, ra});
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0120);
    frame('{ra[7:0], ra[15:8], 8'h44}, 3);
    rc(`HCC_OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0001);
    rc(`HCC_OFF_RXSTAT, 32'hFF7F_FFFF, 32'h0100_0003);
    xfer(1'b1, `HCC_OFF_STATUS, 32'h0000_0002);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0000);
    $display("match done");
    xfer(1'b1, `HCC_OFF_MASK, 32'h0000_00FF);
    xfer(1'b1, `HCC_OFF_ADDR1, 32'h0000_3C55);
    frame('{8'h56, 8'h11}, 0);
    rc(`HCC_OFF_UNMATCH, 32'h0000_FFFF, 32'h0000_0001);
    frame('{8'h55, 8'h24}, 2);
    xfer(1'b1, `HCC_OFF_MAX_FRAME_LENGTH, 32'h0000_0002);
    frame('{8'h55, 8'h18, 8'h24}, 2);
    rc(`HCC_OFF_RXSTAT, 32'h0001_FFFF, 32'h0001_0003);
    chk(32'(exp_q.size()), 32'h0000_0000);
    u_hcc_peer.send(`HCC_FLAG_BYTE);
    u_hcc_peer.send(8'h55);
    xfer(1'b1, `HCC_OFF_CMD, 32'(`HCC_CMD_HUNT));
    rc(`HCC_OFF_RXSTAT, 32'hFF7F_FFFF, 32'h0440_0001);
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0100);
    xfer(1'b1, `HCC_OFF_CMD, 32'(`HCC_CMD_HUNT));
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0120);
    rx_crc_error <= 1'b1;
    frame('{8'h55, 8'h66}, 2);
    rx_crc_error <= 1'b0;
    rc(`HCC_OFF_RXSTAT, 32'hFF7F_FFFF, 32'h0520_0002);
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0121);
    frame('{8'h55, 8'h77}, 0);
    rc(`HCC_OFF_RXSTAT, 32'hFF00_0000, 32'h0500_0000);
    $display("filter done");
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_00B0);
    for (int i = 0; i < 4; i++) xfer(1'b1, `HCC_OFF_TXDATA, 32'(txb[i]));
    xfer(1'b1, `HCC_OFF_TXDATA, 32'h0000_0024);
    chk(32'(rerr), 32'h0000_0001);
    xfer(1'b1, `HCC_OFF_TXCTL, 32'h0000_0001);
    rc(`HCC_OFF_TXSTAT, 32'h0007_0000, 32'h0003_0000);
    xfer(1'b1, `HCC_OFF_CMD, 32'(`HCC_CMD_STOP));
    rc(`HCC_OFF_TXSTAT, 32'h0007_FF04, 32'h0000_0004);
    repeat (40) @(posedge pclk);
    chk(32'(aborts), 32'h0000_0001);
    xfer(1'b1, `HCC_OFF_TXDATA, 32'h0000_003C);
    xfer(1'b1, `HCC_OFF_TXDATA, 32'h0000_005A);
    xfer(1'b1, `HCC_OFF_TXCTL, 32'h0000_0003);
    repeat (200) @(posedge pclk);
    rc(`HCC_OFF_TXSTAT, 32'h0007_0004, 32'h0002_0004);
    xfer(1'b1, `HCC_OFF_CMD, 32'(`HCC_CMD_RESTART));
    rc(`HCC_OFF_TXSTAT, 32'h0000_FF04, 32'h0000_0100);
    rc(`HCC_OFF_TXCTL, 32'h0000_0001, 32'h0000_0000);
    chk(32'(aborts), 32'h0000_0001);
    $display("transmit done");
    xfer(1'b1, `HCC_OFF_STATUS, 32'h0000_0001);
    rc(`HCC_OFF_STATUS, 32'h0000_0061, 32'h0000_0060);
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_02B0);
    cd_n <= 1'b1;
    cts_n <= 1'b1;
    rc(`HCC_OFF_STATUS, 32'h0000_0061, 32'h0000_0001);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0001);
    xfer(1'b1, `HCC_OFF_STATUS, 32'h0000_0001);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0000);
    $display("line status done");
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0230);
    repeat (200) @(posedge pclk);
    xfer(1'b1, `HCC_OFF_CMD, 32'(`HCC_CMD_STOP));
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0220);
    rc(`HCC_OFF_TXSTAT, 32'h0000_0004, 32'h0000_0004);
    xfer(1'b1, `HCC_OFF_CMD, 32'(`HCC_CMD_RESTART));
    xfer(1'b1, `HCC_OFF_MODE, 32'h0000_0230);
    rc(`HCC_OFF_TXSTAT, 32'h0000_0004, 32'h0000_0000);
    $display("enable order done");
    summarize();
  end
endmodule : hcc_channel_test
`default_nettype wire
